/* crs_params.svh */
// constants of the cpu register set: offsets, field positions, reset values, memory map
`ifndef CRS_PARAMS_SVH
`define CRS_PARAMS_SVH
// register indices on the plain port
`define CRS_OFF_DATA0 5'h00
`define CRS_OFF_DATA1 5'h01
`define CRS_OFF_DATA2 5'h02
`define CRS_OFF_DATA3 5'h03
`define CRS_OFF_ADDR0 5'h04
`define CRS_OFF_ADDR1 5'h05
`define CRS_OFF_FRAME 5'h06
`define CRS_OFF_VTB 5'h07
`define CRS_OFF_NIP 5'h08
`define CRS_OFF_USP 5'h09
`define CRS_OFF_ISP 5'h0a
`define CRS_OFF_SBASE 5'h0b
`define CRS_OFF_FLAGS 5'h0c
`define CRS_OFF_D0U 5'h0d
`define CRS_OFF_D0L 5'h0e
`define CRS_OFF_D1U 5'h0f
`define CRS_OFF_D1L 5'h10
`define CRS_OFF_PAIRL 5'h11
`define CRS_OFF_PAIRH 5'h12
`define CRS_OFF_APAIR 5'h13
`define CRS_OFF_SP 5'h14
// flag word bit positions
`define CRS_FLG_C 0
`define CRS_FLG_D 1
`define CRS_FLG_Z 2
`define CRS_FLG_S 3
`define CRS_FLG_B 4
`define CRS_FLG_O 5
`define CRS_FLG_I 6
`define CRS_FLG_U 7
`define CRS_FLG_RSV 11
`define CRS_FLG_IPL_LO 12
`define CRS_FLG_MASK 16'h70ff
`define CRS_FLG_RESET 16'h0000
`define CRS_SWI_USER_MAX 6'h1f
// address map
`define CRS_MAP_TOP 20'hfffff
`define CRS_DFL_LO 20'h03000
`define CRS_DFL_HI 20'h03fff
`define CRS_RAM_LO 20'h00400
`define CRS_VEC_LO 20'h08000
`define CRS_VEC_HI 20'h0ffff
`define CRS_SFR0_HI 20'h002ff
`define CRS_SFR1_LO 20'h02c00
`define CRS_SFR1_HI 20'h02fff
`endif

/* crs_pkg.sv */
// types of the cpu register set
package crs_pkg;
    typedef struct packed {
        logic [15:0] data_word_zero;
        logic [15:0] data_word_one;
        logic [15:0] data_word_two;
        logic [15:0] data_word_three;
        logic [15:0] addr_word_zero;
        logic [15:0] addr_word_one;
        logic [15:0] frame_base_pointer;
    } crs_bank_t;
    typedef enum logic [1:0] {CRS_REG_NONE, CRS_REG_RAM, CRS_REG_DFL, CRS_REG_SFR} crs_region_t;
    typedef struct packed {
        logic alu_valid;
        logic [15:0] result;
        logic carry;
        logic ovf;
        logic byte_op;
    } crs_alu_t;
    typedef struct packed {
        logic take;
        logic hw;
        logic [5:0] swi_num;
        logic [2:0] prio;
    } crs_irq_t;
    typedef struct packed {
        crs_bank_t bank0;
        crs_bank_t bank1;
        logic [19:0] vector_table_base;
        logic [19:0] next_instruction_pointer;
        logic [15:0] user_stack_pointer;
        logic [15:0] interrupt_stack_pointer;
        logic [15:0] static_base_pointer;
        logic [15:0] cpu_flag_word;
        logic [15:0] sp;
        logic [31:0] rdata;
        logic accept;
        logic [1:0] region;
        logic vec_hit;
        logic reserved_hit;
    } crs_state_t;
endpackage

/* crs_regs.sv */
// programmer-visible register set, flag word and address map of the cpu core
`timescale 1ns/100ps
`include "crs_params.svh"
module crs_regs (
    input wire logic clk, // 10 MHz cpu clock
    input wire logic rst, // asynchronous reset, active high
    input wire logic [4:0] addr, // register index
    input wire logic [31:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    output logic [31:0] rdata, // read data, cycle after rd
    input wire crs_pkg::crs_alu_t alu, // alu result and flags
    input wire crs_pkg::crs_irq_t irq, // interrupt request
    output logic irq_accept, // request accepted, one-cycle pulse
    input wire logic [19:0] mem_addr, // address to classify
    output logic [1:0] mem_region, // region of mem_addr
    output logic mem_vec_hit, // mem_addr in fixed vector table
    output logic mem_reserved_hit, // peripheral hole flag, always driven low
    output logic [15:0] flags, // current flag word
    output logic [15:0] stack_pointer // selected stack pointer
);
    crs_pkg::crs_state_t s_q;
    crs_pkg::crs_state_t s_d;
    crs_pkg::crs_bank_t bank;

    // inclusive range test, shared by the upper peripheral, data flash and vector table windows
    function automatic logic in_span(input logic [19:0] a, input logic [19:0] lo,
        input logic [19:0] hi);
        in_span = (a >= lo) && (a <= hi);
    endfunction

    // map classification; peripheral windows are tested first since the upper one sits inside ram span
    function automatic crs_pkg::crs_region_t region_of(input logic [19:0] a);
        if (a <= `CRS_SFR0_HI || in_span(a, `CRS_SFR1_LO, `CRS_SFR1_HI)) begin
            region_of = crs_pkg::CRS_REG_SFR;
        end else if (in_span(a, `CRS_DFL_LO, `CRS_DFL_HI)) begin
            region_of = crs_pkg::CRS_REG_DFL;
        end else if (a >= `CRS_RAM_LO && a < `CRS_DFL_LO) begin
            region_of = crs_pkg::CRS_REG_RAM;
        end else begin
            region_of = crs_pkg::CRS_REG_NONE;
        end
    endfunction

    // bank decode is used by both the read path and the write path
    function automatic logic sel_bank1(input logic [15:0] f);
        sel_bank1 = f[`CRS_FLG_B];
    endfunction

    // next state
    always_comb begin
        logic [15:0] f;
        logic [15:0] res;
        logic neg;
        f = 16'h0000;
        res = 16'h0000;
        neg = 1'b0;
        s_d = s_q;
        s_d.accept = 1'b0;
        bank = sel_bank1(s_q.cpu_flag_word) ? s_q.bank1 : s_q.bank0;
        // register writes; data, address and frame words go through the active bank
        if (wr) begin
            if (addr == `CRS_OFF_DATA0) begin
                bank.data_word_zero = wdata[15:0];
            end else if (addr == `CRS_OFF_DATA1) begin
                bank.data_word_one = wdata[15:0];
            end else if (addr == `CRS_OFF_DATA2) begin
                bank.data_word_two = wdata[15:0];
            end else if (addr == `CRS_OFF_DATA3) begin
                bank.data_word_three = wdata[15:0];
            end else if (addr == `CRS_OFF_D0U) begin
                bank.data_word_zero[15:8] = wdata[7:0];
            end else if (addr == `CRS_OFF_D0L) begin
                bank.data_word_zero[7:0] = wdata[7:0];
            end else if (addr == `CRS_OFF_D1U) begin
                bank.data_word_one[15:8] = wdata[7:0];
            end else if (addr == `CRS_OFF_D1L) begin
                bank.data_word_one[7:0] = wdata[7:0];
            end else if (addr == `CRS_OFF_PAIRL) begin
                bank.data_word_two = wdata[31:16];
                bank.data_word_zero = wdata[15:0];
            end else if (addr == `CRS_OFF_PAIRH) begin
                bank.data_word_three = wdata[31:16];
                bank.data_word_one = wdata[15:0];
            end else if (addr == `CRS_OFF_ADDR0) begin
                bank.addr_word_zero = wdata[15:0];
            end else if (addr == `CRS_OFF_ADDR1) begin
                bank.addr_word_one = wdata[15:0];
            end else if (addr == `CRS_OFF_APAIR) begin
                bank.addr_word_one = wdata[31:16];
                bank.addr_word_zero = wdata[15:0];
            end else if (addr == `CRS_OFF_FRAME) begin
                bank.frame_base_pointer = wdata[15:0];
            end else if (addr == `CRS_OFF_SBASE) begin
                s_d.static_base_pointer = wdata[15:0];
            end else if (addr == `CRS_OFF_VTB) begin
                s_d.vector_table_base = wdata[19:0];
            end else if (addr == `CRS_OFF_NIP) begin
                s_d.next_instruction_pointer = wdata[19:0];
            end else if (addr == `CRS_OFF_USP) begin
                s_d.user_stack_pointer = wdata[15:0];
            end else if (addr == `CRS_OFF_ISP) begin
                s_d.interrupt_stack_pointer = wdata[15:0];
            end else if (addr == `CRS_OFF_SP) begin
                // writes the pointer that the stack flag currently picks
                if (s_q.cpu_flag_word[`CRS_FLG_U]) begin
                    s_d.user_stack_pointer = wdata[15:0];
                end else begin
                    s_d.interrupt_stack_pointer = wdata[15:0];
                end
            end else if (addr == `CRS_OFF_FLAGS) begin
                // only the 11 defined bits are stored; the reserved bit reads low, never rely on it
                s_d.cpu_flag_word = wdata[15:0] & `CRS_FLG_MASK;
            end
        end
        if (sel_bank1(s_q.cpu_flag_word)) begin
            s_d.bank1 = bank;
        end else begin
            s_d.bank0 = bank;
        end
        f = s_d.cpu_flag_word;
        // alu flags; a later hardware update wins over a software flag write
        if (alu.alu_valid) begin
            res = alu.byte_op ? {8'h00, alu.result[7:0]} : alu.result;
            neg = alu.byte_op ? alu.result[7] : alu.result[15];
            f[`CRS_FLG_C] = alu.carry;
            f[`CRS_FLG_Z] = (res == 16'h0000);
            f[`CRS_FLG_S] = neg;
            f[`CRS_FLG_O] = alu.ovf;
        end
        // acceptance: hardware requests need enable and strictly higher priority;
        // a software interrupt instruction is not maskable, it is taken when executed
        if (irq.take && (!irq.hw || (s_q.cpu_flag_word[`CRS_FLG_I] &&
            irq.prio > s_q.cpu_flag_word[`CRS_FLG_IPL_LO +: 3]))) begin
            s_d.accept = 1'b1;
            f[`CRS_FLG_I] = 1'b0;
            if (irq.hw || irq.swi_num <= `CRS_SWI_USER_MAX) begin
                f[`CRS_FLG_U] = 1'b0;
            end
        end
        s_d.cpu_flag_word = f;
        // read data, valid in the cycle after rd only
        s_d.rdata = 32'h0000_0000;
        if (rd) begin
            if (addr == `CRS_OFF_DATA0) begin
                s_d.rdata = {16'h0000, bank.data_word_zero};
            end else if (addr == `CRS_OFF_DATA1) begin
                s_d.rdata = {16'h0000, bank.data_word_one};
            end else if (addr == `CRS_OFF_DATA2) begin
                s_d.rdata = {16'h0000, bank.data_word_two};
            end else if (addr == `CRS_OFF_DATA3) begin
                s_d.rdata = {16'h0000, bank.data_word_three};
            end else if (addr == `CRS_OFF_D0U) begin
                s_d.rdata = {24'h000000, bank.data_word_zero[15:8]};
            end else if (addr == `CRS_OFF_D0L) begin
                s_d.rdata = {24'h000000, bank.data_word_zero[7:0]};
            end else if (addr == `CRS_OFF_D1U) begin
                s_d.rdata = {24'h000000, bank.data_word_one[15:8]};
            end else if (addr == `CRS_OFF_D1L) begin
                s_d.rdata = {24'h000000, bank.data_word_one[7:0]};
            end else if (addr == `CRS_OFF_PAIRL) begin
                s_d.rdata = {bank.data_word_two, bank.data_word_zero};
            end else if (addr == `CRS_OFF_PAIRH) begin
                s_d.rdata = {bank.data_word_three, bank.data_word_one};
            end else if (addr == `CRS_OFF_ADDR0) begin
                s_d.rdata = {16'h0000, bank.addr_word_zero};
            end else if (addr == `CRS_OFF_ADDR1) begin
                s_d.rdata = {16'h0000, bank.addr_word_one};
            end else if (addr == `CRS_OFF_APAIR) begin
                s_d.rdata = {bank.addr_word_one, bank.addr_word_zero};
            end else if (addr == `CRS_OFF_FRAME) begin
                s_d.rdata = {16'h0000, bank.frame_base_pointer};
            end else if (addr == `CRS_OFF_SBASE) begin
                s_d.rdata = {16'h0000, s_q.static_base_pointer};
            end else if (addr == `CRS_OFF_VTB) begin
                s_d.rdata = {12'h000, s_q.vector_table_base};
            end else if (addr == `CRS_OFF_NIP) begin
                s_d.rdata = {12'h000, s_q.next_instruction_pointer};
            end else if (addr == `CRS_OFF_USP) begin
                s_d.rdata = {16'h0000, s_q.user_stack_pointer};
            end else if (addr == `CRS_OFF_ISP) begin
                s_d.rdata = {16'h0000, s_q.interrupt_stack_pointer};
            end else if (addr == `CRS_OFF_SP) begin
                s_d.rdata = {16'h0000, s_q.sp};
            end else if (addr == `CRS_OFF_FLAGS) begin
                s_d.rdata = {16'h0000, s_q.cpu_flag_word};
            end
        end
        // address classification, registered
        s_d.region = region_of(mem_addr);
        s_d.vec_hit = in_span(mem_addr, `CRS_VEC_LO, `CRS_VEC_HI);
        // holes: this block knows no allocation, so the flag stays low; callers keep out of them
        s_d.reserved_hit = 1'b0;
        // selected pointer has its own flop so the port comes straight from a register
        s_d.sp = s_d.cpu_flag_word[`CRS_FLG_U] ? s_d.user_stack_pointer :
            s_d.interrupt_stack_pointer;
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops
    assign rdata = s_q.rdata;
    assign irq_accept = s_q.accept;
    assign mem_region = s_q.region;
    assign mem_vec_hit = s_q.vec_hit;
    assign mem_reserved_hit = s_q.reserved_hit;
    assign flags = s_q.cpu_flag_word;
    assign stack_pointer = s_q.sp;
endmodule

/* crs_regs_sva.sv */
// port checker for the cpu register set, bound onto crs_regs
`timescale 1ns/100ps
`include "crs_params.svh"
module crs_regs_chk (
    input wire logic clk, // cpu clock
    input wire logic rst, // async reset
    input wire logic [4:0] addr, // index
    input wire logic [31:0] wdata, // write data
    input wire logic wr, // write strobe
    input wire logic rd, // read strobe
    input wire logic [31:0] rdata, // read data
    input wire crs_pkg::crs_alu_t alu, // alu result
    input wire crs_pkg::crs_irq_t irq, // request
    input wire logic irq_accept, // accept pulse
    input wire logic [19:0] mem_addr, // address
    input wire logic [1:0] mem_region, // region
    input wire logic mem_vec_hit, // vector hit
    input wire logic mem_reserved_hit, // hole hit
    input wire logic [15:0] flags, // flag word
    input wire logic [15:0] stack_pointer // stack pointer
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // zero and sign only judged on word ops, byte ops look at the low byte
    wire arith = alu.alu_valid && !alu.byte_op;
    // software interrupts bypass enable and level
    wire take_ok = irq.take && (!irq.hw || (flags[`CRS_FLG_I] && (irq.prio > flags[14:12])));
    // write then read of data word zero, one idle cycle between
    sequence s_wr0; wr && addr == `CRS_OFF_DATA0; endsequence
    sequence s_rd0; rd && addr == `CRS_OFF_DATA0; endsequence
    property p_readback; s_wr0 ##2 s_rd0 |=> rdata == {16'h0000, $past(wdata[15:0], 3)};
    endproperty
    a_readback: assert property (p_readback) else $error("data word readback wrong");
    property p_idle; !rd |=> rdata == 32'h00000000; endproperty
    a_idle: assert property (p_idle) else $error("read data outside read slot");
    property p_zero; arith |=> flags[`CRS_FLG_Z] == ($past(alu.result) == 16'h0000); endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_sign; arith |=> flags[`CRS_FLG_S] == $past(alu.result[15]); endproperty
    a_sign: assert property (p_sign) else $error("sign flag wrong");
    property p_carry; alu.alu_valid |=> flags[`CRS_FLG_C] == $past(alu.carry); endproperty
    a_carry: assert property (p_carry) else $error("carry flag wrong");
    property p_ovf; alu.alu_valid |=> flags[`CRS_FLG_O] == $past(alu.ovf); endproperty
    a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
    property p_accept; take_ok |=> irq_accept && !flags[`CRS_FLG_I]; endproperty
    a_accept: assert property (p_accept) else $error("request not taken");
    property p_refuse; !take_ok |=> !irq_accept; endproperty
    a_refuse: assert property (p_refuse) else $error("request taken at or below level");
    property p_uclr; irq_accept && $past(irq.hw || irq.swi_num <= `CRS_SWI_USER_MAX) |-> !flags[7];
    endproperty
    a_uclr: assert property (p_uclr) else $error("stack flag not cleared");
    property p_dfl; mem_addr >= `CRS_DFL_LO && mem_addr <= `CRS_DFL_HI |=> mem_region == 2'h2;
    endproperty
    a_dfl: assert property (p_dfl) else $error("data flash region wrong");
    property p_vec; mem_addr >= `CRS_VEC_LO && mem_addr <= `CRS_VEC_HI |=> mem_vec_hit; endproperty
    a_vec: assert property (p_vec) else $error("vector table missed");
    property p_sfr; mem_addr <= `CRS_SFR0_HI |=> mem_region == 2'h3; endproperty
    a_sfr: assert property (p_sfr) else $error("peripheral region wrong");
endmodule
bind crs_regs crs_regs_chk i_crs_regs_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .alu(alu), .irq(irq), .irq_accept(irq_accept),
    .mem_addr(mem_addr), .mem_region(mem_region), .mem_vec_hit(mem_vec_hit),
    .mem_reserved_hit(mem_reserved_hit), .flags(flags), .stack_pointer(stack_pointer));

/* test_cpu_register_set_and_flags.sv */
// self-checking bench for the cpu register set
`timescale 1ns/100ps
module test_cpu_register_set_and_flags;
    typedef struct {logic [4:0] wa; logic [31:0] wd; logic [4:0] ra; logic [31:0] ex;} crs_row_t;
    // write one index, read one index; later rows lean on earlier ones
    crs_row_t rows[20] = '{'{5'h00, 32'hffff1234, 5'h00, 32'h00001234},
        '{5'h0d, 32'h000000ab, 5'h00, 32'h0000ab34}, '{5'h0e, 32'h000000cd, 5'h00, 32'h0000abcd},
        '{5'h02, 32'h00005678, 5'h11, 32'h5678abcd}, '{5'h03, 32'h00003333, 5'h12, 32'h33330000},
        '{5'h10, 32'h00000011, 5'h12, 32'h33330011}, '{5'h0f, 32'h00000022, 5'h01, 32'h00002211},
        '{5'h04, 32'h0000a0a0, 5'h13, 32'h0000a0a0}, '{5'h05, 32'h0000a1a1, 5'h13, 32'ha1a1a0a0},
        '{5'h06, 32'h0000fbfb, 5'h06, 32'h0000fbfb}, '{5'h0b, 32'h00005b5b, 5'h0b, 32'h00005b5b},
        '{5'h07, 32'hffffffff, 5'h07, 32'h000fffff}, '{5'h08, 32'hffffffff, 5'h08, 32'h000fffff},
        '{5'h09, 32'h00001357, 5'h09, 32'h00001357}, '{5'h14, 32'h00009753, 5'h0a, 32'h00009753},
        '{5'h0a, 32'h00002468, 5'h14, 32'h00002468}, '{5'h11, 32'h1111abcd, 5'h02, 32'h00001111},
        '{5'h12, 32'h33332211, 5'h03, 32'h00003333}, '{5'h13, 32'hb1b1b0b0, 5'h05, 32'h0000b1b1},
        '{5'h1f, 32'hdeadbeef, 5'h1f, 32'h00000000}};
    logic [15:0] ares[5] = '{16'h0000, 16'h8000, 16'h7fff, 16'hffff, 16'h1200};
    logic [19:0] maddr[10] = '{20'h00000, 20'h002ff, 20'h00400, 20'h03000, 20'h03fff, 20'h08000,
        20'h0ffff, 20'hfffff, 20'h02bff, 20'h02c00};
    logic [2:0] mexp[10] = '{3'h3, 3'h3, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h0, 3'h1, 3'h3};
    logic clk = 1'b0;
    logic rst, wr, rd, irq_accept, mem_vec_hit, mem_reserved_hit;
    logic [4:0] addr;
    logic [31:0] wdata, rdata, v;
    crs_pkg::crs_alu_t alu;
    crs_pkg::crs_irq_t irq;
    logic [19:0] mem_addr;
    logic [1:0] mem_region;
    logic [15:0] flags, stack_pointer;
    int num_errors = 0;
    int checks_done = 0;
    crs_regs i_crs_regs (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .alu(alu), .irq(irq), .irq_accept(irq_accept), .mem_addr(mem_addr),
        .mem_region(mem_region), .mem_vec_hit(mem_vec_hit), .mem_reserved_hit(mem_reserved_hit),
        .flags(flags), .stack_pointer(stack_pointer));
    // 10 MHz clock
    always #50 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wreg(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rreg(input logic [4:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic req(input logic hw, input logic [5:0] n, input logic [2:0] p, input logic e);
        @(posedge clk);
        irq <= {1'b1, hw, n, p};
        @(posedge clk);
        irq.take <= 1'b0;
        #1 chk("accept", {31'h0, e}, {31'h0, irq_accept});
    endtask
    task automatic results;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // watchdog well beyond the roughly 160 cycles the tests take
    initial begin
        #(100 * 5000);
        num_errors++;
        results;
    end
    initial begin
        rst = 1'b1;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        alu = '0;
        irq = '0;
        mem_addr = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rreg(5'h0c, v);
        chk("flags after reset", 32'h0, v);
        foreach (rows[i]) begin
            wreg(rows[i].wa, rows[i].wd);
            rreg(rows[i].ra, v);
            chk("row readback", rows[i].ex,
                v);
        end
        // bank one, interrupts on, level 3
        wreg(5'h0c, 32'h00003050);
        rreg(5'h0c, v);
        chk("flag word", 32'h00003050, v & 32'h000070ff);
        rreg(5'h00, v);
        chk("bank one word", 32'h0, v);
        wreg(5'h00, 32'h00009999);
        wreg(5'h0c, 32'h000030c0);
        rreg(5'h00, v);
        chk("bank zero word", 32'h0000abcd, v);
        chk("user stack", 32'h00001357, {16'h0, stack_pointer});
        req(1'b1, 6'h00, 3'h3, 1'b0);
        req(1'b0, 6'h20, 3'h4, 1'b1);
        chk("stack flag kept", 32'h1, {31'h0, flags[7]});
        req(1'b1, 6'h00, 3'h7, 1'b0);
        wreg(5'h0c, 32'h000030c0);
        req(1'b0, 6'h1f, 3'h4, 1'b1);
        chk("interrupt stack", 32'h00002468, {16'h0, stack_pointer});
        wreg(5'h0c, 32'h000030c0);
        req(1'b1, 6'h00, 3'h4, 1'b1);
        chk("hw stack flag", 32'h0, {31'h0, flags[7]});
        // software interrupt with enable off and low level is still taken
        wreg(5'h0c, 32'h00003080);
        req(1'b0, 6'h05, 3'h0, 1'b1);
        chk("swi stack flag", 32'h0, {31'h0, flags[7]});
        // last row is a byte op whose low byte is zero
        for (int k = 0; k < 5; k++) begin
            @(posedge clk);
            alu <= {1'b1, ares[k], k[0], k[1], k == 4};
            @(posedge clk);
            alu.alu_valid <= 1'b0;
            #1 chk("alu flags", {28'h0, k[1], (k == 4) ? ares[k][7] : ares[k][15],
                (k == 4) ? ares[k][7:0] == 8'h0 : ares[k] == 16'h0, k[0]},
                {28'h0, flags[5], flags[3:2], flags[0]});
        end
        for (int k = 0; k < 10; k++) begin
            @(posedge clk);
            mem_addr <= maddr[k];
            @(posedge clk);
            #1 chk("map", {29'h0, mexp[k]},
                {28'h0, mem_reserved_hit, mem_vec_hit, mem_region});
        end
        // second reset in mid-run
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        rreg(5'h00, v);
        chk("word after reset", 32'h0, v);
        results;
    end
endmodule
